// ==== sport_pkg.sv ====
// Package with register map, field positions and types of the serial port buffer block.
package sport_pkg;
  localparam logic [3:0] ADDR_CTL = 4'h0;
  localparam logic [3:0] ADDR_DIV = 4'h1;
  localparam logic [3:0] ADDR_TXA = 4'h2;
  localparam logic [3:0] ADDR_TXB = 4'h3;
  localparam logic [3:0] ADDR_RXA = 4'h4;
  localparam logic [3:0] ADDR_RXB = 4'h5;
  localparam logic [3:0] ADDR_MASK = 4'h6;
  localparam int CTL_EN_A = 0;
  localparam int CTL_ICLK = 10;
  localparam int CTL_FSR = 13;
  localparam int CTL_IFS = 14;
  localparam int CTL_MCH = 15;
  localparam int CTL_DATA_INDEPENDENT_SYNC = 16;
  localparam int CTL_DMA_A = 18;
  localparam int CTL_DMA_B = 20;
  localparam int CTL_HANG_DIS = 23;
  localparam int CTL_EN_B = 24;
  localparam int CTL_DIR = 25;
  localparam int CTL_FLAG_B = 26;
  localparam int CTL_FILL_B = 27;
  localparam int CTL_FLAG_A = 29;
  localparam int CTL_FILL_A = 30;
  localparam logic [31:0] CTL_WMASK = 32'h03F5E401;
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  localparam logic [31:0] DIV_RESET = 32'h00000000;
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  localparam logic [1:0] FILL_PART = 2'h2;
  localparam logic [1:0] FILL_FULL = 2'h3;
  localparam int SERIAL_CLOCK_DIVISOR_W = 15;
  localparam int FRAME_SYNC_DIVISOR_W = 16;
  localparam int FRAME_SYNC_DIVISOR_LSB = 16;
  localparam int CORE_PER_SCLK = 4;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic sclk_out;
    logic sclk_oe;
    logic fs_out;
    logic fs_oe;
  } link_drv_t;
endpackage

// ==== sport_buf.sv ====
// Serial port channel buffers, fill status, sticky error flags, core hang and clock dividers.
`timescale 1ns/100ps
`default_nettype none
module sport_buf #(
  parameter bit ODD_PORT = 1'b0
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Register port.
  input wire sport_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  output logic core_stall,
  // Link pins.
  input wire logic sclk_in,
  input wire logic fs_in,
  input wire logic [1:0] data_in,
  output logic [1:0] data_out,
  output logic [1:0] data_oe,
  output sport_pkg::link_drv_t link,
  // Interrupt request to the core.
  output logic irq
);
  localparam int SW = 5;
  // Registers.
  logic [31:0] ctl_r;
  logic [31:0] div_r;
  logic [1:0] mask_r;
  logic [1:0] uflow_r;
  logic [1:0] oflow_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic [1:0][31:0] txbuf_r;
  logic [1:0] txv_r;
  logic [1:0][31:0] txsh_r;
  logic [1:0] shv_r;
  logic [1:0][1:0][31:0] rxbuf_r;
  logic [1:0][1:0] rxv_r;
  logic [1:0][31:0] rxsh_r;
  logic [SW-1:0] bitcnt_r;
  logic active_r;
  logic [2:0] sclk_s_r;
  logic [2:0] fs_s_r;
  logic [1:0][1:0] din_s_r;
  logic [14:0] cdiv_r;
  logic [1:0] ph_r;
  logic isclk_r;
  logic [15:0] fcnt_r;
  logic ifs_r;
  logic en_d_r;

  // Decoded control fields.
  wire dir_tx = ctl_r[sport_pkg::CTL_DIR];
  wire [1:0] en = {ctl_r[sport_pkg::CTL_EN_B], ctl_r[sport_pkg::CTL_EN_A]};
  wire en_any = |en;
  wire mch = ctl_r[sport_pkg::CTL_MCH];
  wire frame_sync_required = ctl_r[sport_pkg::CTL_FSR];
  wire [1:0] dma = {ctl_r[sport_pkg::CTL_DMA_B], ctl_r[sport_pkg::CTL_DMA_A]};
  wire hang_dis = ctl_r[sport_pkg::CTL_HANG_DIS];
  wire [14:0] serial_clock_divisor = div_r[sport_pkg::SERIAL_CLOCK_DIVISOR_W-1:0];
  wire [15:0] frame_sync_divisor = div_r[sport_pkg::FRAME_SYNC_DIVISOR_LSB +: sport_pkg::FRAME_SYNC_DIVISOR_W];

  // Bus strobes.
  wire wr_ctl = bus.wr && bus.addr == sport_pkg::ADDR_CTL;
  wire wr_div = bus.wr && bus.addr == sport_pkg::ADDR_DIV;
  wire wr_mask = bus.wr && bus.addr == sport_pkg::ADDR_MASK;
  wire [1:0] wr_tx = {bus.wr && bus.addr == sport_pkg::ADDR_TXB,
                      bus.wr && bus.addr == sport_pkg::ADDR_TXA};
  wire [1:0] rd_rx = {bus.rd && bus.addr == sport_pkg::ADDR_RXB,
                      bus.rd && bus.addr == sport_pkg::ADDR_RXA};

  // Link clock rising edges, seen only after two sampling stages.
  wire sclk_ext_rise = sclk_s_r[1] && !sclk_s_r[2];
  // External sync is a level, judged at the serial clock edge that samples it.
  wire fs_ext = fs_s_r[1];
  wire iclk = ctl_r[sport_pkg::CTL_ICLK];
  wire sclk_tick = iclk ? (ph_r == 2'h3 && cdiv_r == '0) : sclk_ext_rise;
  wire fs_int = ctl_r[sport_pkg::CTL_IFS];
  wire fdiv_hit = fcnt_r == frame_sync_divisor;
  // Internal sync held high for a zero divisor.
  wire ifs_level = (frame_sync_divisor == '0) || ifs_r;
  // Data-dependent syncs only in multichannel transmit with the option clear.
  wire need_data = mch && dir_tx && !ctl_r[sport_pkg::CTL_DATA_INDEPENDENT_SYNC];
  wire have_data = (txv_r | shv_r) != 2'b00;
  wire fs_gen = fs_int && sclk_tick && fdiv_hit && (!need_data || have_data);
  wire fs_ev = en_any && (fs_int ? fs_gen : fs_ext && sclk_tick);
  wire word_end = active_r && sclk_tick && bitcnt_r == SW'(31);
  // A word is due at every word boundary when no sync is required.
  wire word_due = !frame_sync_required && en_any && sclk_tick && (!active_r || word_end);
  wire start = frame_sync_required ? fs_ev : word_due;

  // Fill status per channel, transmit or receive by direction.
  logic [1:0][1:0] fill;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      if (dir_tx) begin
        fill[c] = txv_r[c] ? (shv_r[c] ? sport_pkg::FILL_FULL : sport_pkg::FILL_PART)
                           : sport_pkg::FILL_EMPTY;
      end else begin
        fill[c] = rxv_r[c][1] ? sport_pkg::FILL_FULL
                : rxv_r[c][0] ? sport_pkg::FILL_PART : sport_pkg::FILL_EMPTY;
      end
    end
  end

  // Error bit 29 is fixed by port parity in multichannel mode.
  wire flag_a = mch ? (ODD_PORT ? oflow_r[0] : uflow_r[0])
                    : (dir_tx ? uflow_r[0] : oflow_r[0]);
  wire flag_b = dir_tx ? uflow_r[1] : oflow_r[1];
  wire [31:0] ctl_view = {fill[0], flag_a, fill[1], flag_b,
                          ctl_r[25:0] & sport_pkg::CTL_WMASK[25:0]};

  // Stall while a core access meets a buffer it cannot use.
  assign core_stall = !hang_dis && ((|(wr_tx & txv_r & shv_r)) ||
                      (rd_rx[0] && !rxv_r[0][0]) || (rd_rx[1] && !rxv_r[1][0]));

  // Read data mux.
  logic [31:0] rmux;
  always_comb begin
    unique case (bus.addr)
      sport_pkg::ADDR_CTL: rmux = ctl_view;
      sport_pkg::ADDR_DIV: rmux = div_r;
      sport_pkg::ADDR_RXA: rmux = rxbuf_r[0][0];
      sport_pkg::ADDR_RXB: rmux = rxbuf_r[1][0];
      sport_pkg::ADDR_MASK: rmux = {30'h00000000, mask_r};
      default: rmux = 32'h00000000;
    endcase
  end

  // Control registers and read data.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctl_r <= sport_pkg::CTL_RESET;
      div_r <= sport_pkg::DIV_RESET;
      mask_r <= 2'h0;
      rdata_r <= 32'h00000000;
      en_d_r <= 1'b0;
    end else begin
      if (wr_ctl) ctl_r <= bus.wdata & sport_pkg::CTL_WMASK;
      if (wr_div) div_r <= bus.wdata;
      if (wr_mask) mask_r <= bus.wdata[1:0];
      rdata_r <= bus.rd ? rmux : 32'h00000000;
      en_d_r <= en_any;
    end
  end

  // Link sampling and internal clock divider.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sclk_s_r <= 3'h0;
      fs_s_r <= 3'h0;
      din_s_r <= '0;
      cdiv_r <= 15'h0000;
      ph_r <= 2'h0;
      isclk_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], sclk_in};
      fs_s_r <= {fs_s_r[1:0], fs_in};
      din_s_r <= {din_s_r[0], data_in};
      if (!en_any) begin
        cdiv_r <= 15'h0000;
        ph_r <= 2'h0;
        isclk_r <= 1'b0;
      end else if (cdiv_r == serial_clock_divisor) begin
        cdiv_r <= 15'h0000;
        ph_r <= ph_r + 2'h1;
        isclk_r <= ph_r[1] ^ (ph_r == 2'h1);
      end else begin
        cdiv_r <= cdiv_r + 15'h0001;
      end
    end
  end

  // Frame sync divider.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fcnt_r <= 16'h0000;
      ifs_r <= 1'b0;
    end else if (en_any && !en_d_r) begin
      fcnt_r <= 16'h0000;
      ifs_r <= 1'b0;
    end else if (sclk_tick) begin
      fcnt_r <= fdiv_hit ? 16'h0000 : fcnt_r + 16'h0001;
      ifs_r <= fs_gen;
    end
  end

  // Buffers, shifters and sticky flags.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txbuf_r <= '0;
      txv_r <= 2'h0;
      txsh_r <= '0;
      shv_r <= 2'h0;
      rxbuf_r <= '0;
      rxv_r <= '0;
      rxsh_r <= '0;
      bitcnt_r <= '0;
      active_r <= 1'b0;
      uflow_r <= 2'h0;
      oflow_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      // Core side updates fill status even with the port off.
      for (int c = 0; c < 2; c++) begin
        if (wr_tx[c] && !(txv_r[c] && shv_r[c] && !hang_dis)) begin
          txbuf_r[c] <= bus.wdata;
          txv_r[c] <= 1'b1;
          // An idle free shifter takes the waiting word, so two words fit.
          if (txv_r[c] && !shv_r[c] && !active_r) begin
            txsh_r[c] <= txbuf_r[c];
            shv_r[c] <= 1'b1;
            if (!dma[c] && !mask_r[0]) irq_r <= 1'b1;
          end
        end
        if (rd_rx[c] && rxv_r[c][0]) begin
          rxbuf_r[c][0] <= rxbuf_r[c][1];
          rxv_r[c] <= {1'b0, rxv_r[c][1]};
        end
      end
      if (!en_any) begin
        uflow_r <= 2'h0;
        oflow_r <= 2'h0;
        active_r <= 1'b0;
        bitcnt_r <= '0;
      end else begin
        if (sclk_tick && active_r) begin
          bitcnt_r <= bitcnt_r + SW'(1);
          for (int c = 0; c < 2; c++) begin
            txsh_r[c] <= {txsh_r[c][30:0], 1'b0};
            rxsh_r[c] <= {rxsh_r[c][30:0], din_s_r[1][c]};
          end
        end
        if (word_end) begin
          active_r <= 1'b0;
          shv_r <= 2'h0;
        end
        if (start) begin
          active_r <= 1'b1;
          bitcnt_r <= '0;
        end
        for (int c = 0; c < 2; c++) begin
          if (dir_tx && en[c]) begin
            // Move the data register into a free shifter.
            if (start && txv_r[c] && (!shv_r[c] || word_end)) begin
              txsh_r[c] <= txbuf_r[c];
              shv_r[c] <= 1'b1;
              txv_r[c] <= wr_tx[c];
              if (!dma[c] && !mask_r[0]) irq_r <= 1'b1;
            end
            if (start && !txv_r[c] && !(shv_r[c] && !word_end)) begin
              uflow_r[c] <= 1'b1;
            end
          end
          if (!dir_tx && en[c] && word_end) begin
            // Word complete: copy into the buffer at once.
            if (!rxv_r[c][0] || (rd_rx[c] && !rxv_r[c][1])) begin
              rxbuf_r[c][0] <= {rxsh_r[c][30:0], din_s_r[1][c]};
              rxv_r[c][0] <= 1'b1;
            end else begin
              rxbuf_r[c][1] <= {rxsh_r[c][30:0], din_s_r[1][c]};
              rxv_r[c][1] <= 1'b1;
              if (rxv_r[c][1] && !rd_rx[c]) oflow_r[c] <= 1'b1;
            end
            if (!dma[c] && !mask_r[1]) irq_r <= 1'b1;
          end
        end
      end
    end
  end

  // Outputs.
  assign rdata = rdata_r;
  assign irq = irq_r;
  assign data_out = {txsh_r[1][31], txsh_r[0][31]};
  assign data_oe = {2{dir_tx}} & en & {2{active_r}};
  assign link.sclk_out = isclk_r;
  assign link.sclk_oe = iclk && en_any;
  assign link.fs_out = ifs_level && en_any;
  assign link.fs_oe = fs_int && en_any;
endmodule
`default_nettype wire

// ==== sport_buf_props.sv ====
// Checker of read timing, register echo, stall and pin enables of the serial port block.
`timescale 1ns/100ps
`default_nettype none
module sport_buf_props (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Observed ports.
  input wire sport_pkg::bus_req_t bus,
  input wire logic [31:0] rdata,
  input wire logic core_stall,
  input wire logic [1:0] data_oe,
  input wire logic irq
);
  logic [31:0] ctl_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Shadow of the writable control bits, so that echoes can be judged.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctl_r <= 32'h00000000;
    end else if (bus.wr && bus.addr == sport_pkg::ADDR_CTL) begin
      ctl_r <= bus.wdata & sport_pkg::CTL_WMASK;
    end
  end
  a_read_gap_zero: assert property (!$past(bus.rd) |-> rdata == 32'h00000000)
    else $error("read data not zero outside a read answer");
  a_irq_one_cycle: assert property (irq |=> !irq)
    else $error("interrupt longer than one cycle");
  a_stall_needs_access: assert property (core_stall |-> bus.wr || bus.rd)
    else $error("stall without an access");
  a_hang_off: assert property (ctl_r[sport_pkg::CTL_HANG_DIS] |-> !core_stall)
    else $error("stall while hang is disabled");
  a_rx_no_drive: assert property (!ctl_r[sport_pkg::CTL_DIR] && !$past(ctl_r[sport_pkg::CTL_DIR])
    |-> data_oe == 2'h0)
    else $error("data pins driven while receiving");
  a_fill_code_legal: assert property ($past(bus.rd && bus.addr == sport_pkg::ADDR_CTL)
    |-> rdata[31:30] != 2'h1 && rdata[28:27] != 2'h1)
    else $error("reserved fill code shown");
  a_flag_when_off: assert property ($past(bus.rd && bus.addr == sport_pkg::ADDR_CTL)
    && $past(!ctl_r[sport_pkg::CTL_EN_A], 2) && $past(!ctl_r[sport_pkg::CTL_EN_A])
    |-> !rdata[sport_pkg::CTL_FLAG_A])
    else $error("error flag set on a disabled channel");
  a_ctl_echo: assert property ($past(bus.rd && bus.addr == sport_pkg::ADDR_CTL)
    |-> (rdata & sport_pkg::CTL_WMASK) == $past(ctl_r))
    else $error("control read differs from written bits");
endmodule
bind sport_buf sport_buf_props sport_buf_props_inst (.mclk(mclk), .reset_n(reset_n), .bus(bus),
  .rdata(rdata), .core_stall(core_stall), .data_oe(data_oe), .irq(irq));
`default_nettype wire

// ==== sport_far_end.sv ====
// Behavioural external serial device that makes clock, frame sync and data.
`timescale 1ns/100ps
`default_nettype none
module sport_far_end (
  // Link pins towards the port.
  output logic sclk,
  output logic fs,
  output logic [1:0] dat
);
  // Idle levels; the clock stands still between frames.
  initial begin
    sclk = 1'b0;
    fs = 1'b0;
    dat = 2'h0;
  end
  // One frame: a sync cycle, then both words MSB first, 200 ns per bit.
  task automatic send(input logic [31:0] wa, input logic [31:0] wb);
    for (int i = 32; i >= 0; i--) begin
      fs = (i == 32);
      if (i < 32) dat = {wb[i], wa[i]};
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    fs = 1'b0;
    dat = ~dat;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the serial port buffer block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [31:0] EN = 32'h01000001;
  localparam logic [31:0] FRAME_SYNC_REQUIRED = 32'h00002000;
  localparam logic [31:0] DIR = 32'h02000000;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  sport_pkg::bus_req_t bus = '0;
  logic [31:0] rdata, m, e, w[4];
  logic [1:0] data_in, data_out, data_oe;
  logic core_stall, sclk_in, fs_in, irq, stall_seen, p;
  logic rd_seen = 1'b0;
  sport_pkg::link_drv_t link;
  logic [31:0] exp_q[$], msk_q[$];
  int t_q[$];
  int n_errors = 0, n_compared = 0, irq_cnt = 0, k;
  always #12.5 mclk = ~mclk;
  sport_buf sport_buf_inst (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .core_stall(core_stall), .sclk_in(sclk_in), .fs_in(fs_in), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .link(link), .irq(irq));
  sport_far_end sport_far_end_inst (.sclk(sclk_in), .fs(fs_in), .dat(data_in));
  // Compares read data with the oldest note and counts interrupt pulses.
  always @(negedge mclk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check(rdata & m, e);
    end
    rd_seen = bus.rd && !core_stall;
    if (irq === 1'b1) irq_cnt++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic acc(input logic [3:0] a, input logic [31:0] d, input logic wr, input logic rd);
    @(posedge mclk);
    bus <= {a, d, wr, rd};
    @(negedge mclk);
    stall_seen = core_stall;
    @(posedge mclk);
    bus <= '0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    acc(a, d, 1'b1, 1'b0);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] x, input logic [31:0] msk);
    acc(a, 32'h00000000, 1'b0, 1'b1);
    exp_q.push_back(x & msk);
    msk_q.push_back(msk);
  endtask
  task automatic frame(input logic [31:0] a, input int n);
    k = irq_cnt;
    sport_far_end_inst.send(a, ~a);
    for (int i = 0; i < 20 && irq_cnt - k < n; i++) @(posedge mclk);
    repeat (6) @(posedge mclk);
    check(32'(irq_cnt - k), 32'(n));
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #500000;
    n_errors++;
    conclude();
  end
  // Main sequence.
  initial begin
    void'($urandom(95));
    for (int i = 0; i < 4; i++) w[i] = $urandom;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rreg(sport_pkg::ADDR_CTL, sport_pkg::CTL_RESET, 32'hFFFFFFFF);
    rreg(sport_pkg::ADDR_DIV, sport_pkg::DIV_RESET, 32'hFFFFFFFF);
    rreg(4'hF, 32'h00000000, 32'hFFFFFFFF);
    $display("test reset done");
    wreg(sport_pkg::ADDR_MASK, 32'h00000000);
    wreg(sport_pkg::ADDR_CTL, EN | FRAME_SYNC_REQUIRED);
    acc(sport_pkg::ADDR_RXA, 32'h00000000, 1'b0, 1'b1);
    check({31'h0, stall_seen}, 32'h00000001);
    frame(w[0], 1);
    rreg(sport_pkg::ADDR_CTL, 32'h90000000, 32'hFC000000);
    rreg(sport_pkg::ADDR_RXA, w[0], 32'hFFFFFFFF);
    rreg(sport_pkg::ADDR_RXB, ~w[0], 32'hFFFFFFFF);
    wreg(sport_pkg::ADDR_MASK, 32'h00000002);
    for (int i = 1; i < 4; i++) frame(w[i], 0);
    rreg(sport_pkg::ADDR_CTL, 32'hFC000000, 32'hFC000000);
    rreg(sport_pkg::ADDR_RXA, w[1], 32'hFFFFFFFF);
    rreg(sport_pkg::ADDR_RXA, w[3], 32'hFFFFFFFF);
    wreg(sport_pkg::ADDR_CTL, FRAME_SYNC_REQUIRED);
    rreg(sport_pkg::ADDR_CTL, 32'h00000000, 32'h24000000);
    $display("test receive done");
    wreg(sport_pkg::ADDR_CTL, EN | FRAME_SYNC_REQUIRED | DIR);
    frame(w[0], 0);
    rreg(sport_pkg::ADDR_CTL, 32'h24000000, 32'h24000000);
    wreg(sport_pkg::ADDR_CTL, DIR);
    rreg(sport_pkg::ADDR_CTL, 32'h00000000, 32'h24000000);
    wreg(sport_pkg::ADDR_TXA, w[1]);
    rreg(sport_pkg::ADDR_CTL, 32'h80000000, 32'hE0000000);
    wreg(sport_pkg::ADDR_TXA, w[2]);
    rreg(sport_pkg::ADDR_CTL, 32'hC0000000, 32'hE0000000);
    acc(sport_pkg::ADDR_TXA, w[3], 1'b1, 1'b0);
    check({31'h0, stall_seen}, 32'h00000001);
    wreg(sport_pkg::ADDR_CTL, DIR | 32'h00800000);
    acc(sport_pkg::ADDR_TXA, w[3], 1'b1, 1'b0);
    check({31'h0, stall_seen}, 32'h00000000);
    $display("test transmit done");
    wreg(sport_pkg::ADDR_DIV, 32'h00000001);
    wreg(sport_pkg::ADDR_CTL, 32'h00000401);
    p = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (link.sclk_out === 1'b1 && !p) t_q.push_back(i);
      p = link.sclk_out;
    end
    check(32'(t_q[1] - t_q[0]), 32'h00000008);
    $display("test divider done");
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule
`default_nettype wire
